// ---- adc_seq_pkg.sv ----
/*
 * Constants shared by the serial conversion sequencer and its helpers:
 * frame geometry, control word layout, reset values and clock figures.
 * Assumes nothing of its surroundings; compiled before every module.
 */
`default_nettype none
package adc_seq_pkg;
   // -------------------------------------------------------------------
   // Conversion geometry
   // -------------------------------------------------------------------
   localparam int unsigned CONV_CYCLES  = 16;
   localparam int unsigned TRACK_CYCLES = 3;
   localparam int unsigned LEAD_ZEROS   = 4;
   localparam int unsigned RESULT_BITS  = 12;
   localparam int unsigned CODE_STEPS   = 4096;
   localparam int unsigned IDX_W        = 5;
   localparam logic [4:0]  IDX_IDLE     = 5'h00;
   localparam logic [4:0]  IDX_FIRST    = 5'h01;
   localparam logic [4:0]  IDX_HOLD     = 5'(TRACK_CYCLES + 1);
   localparam logic [4:0]  IDX_LAST_Z   = 5'(LEAD_ZEROS);
   localparam logic [4:0]  IDX_LAST     = 5'(CONV_CYCLES);
   // -------------------------------------------------------------------
   // Control word layout
   // -------------------------------------------------------------------
   localparam int unsigned CTRL_BITS    = 8;
   localparam int unsigned CHAN_MSB     = 5;
   localparam int unsigned CHAN_LSB     = 3;
   localparam int unsigned CHAN_W       = 3;
   localparam logic [4:0]  CTRL_COUNT   = 5'(CTRL_BITS);
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [2:0]  CHAN_RESET   = 3'h0;
   localparam logic [11:0] CODE_RESET   = 12'h000;
   // -------------------------------------------------------------------
   // Clock figures
   // -------------------------------------------------------------------
   localparam int unsigned MCLK_PERIOD_NS = 20;
   localparam int unsigned SYNC_STAGES    = 2;
   typedef enum logic [1:0] {
      PH_DOWN,
      PH_TRACK,
      PH_HOLD
   } phase_e;
endpackage : adc_seq_pkg
`default_nettype wire

// ---- sync_bit.sv ----
/*
 * Two-flop synchroniser for one level from outside the mclk domain.
 * Assumes the input may change at any time relative to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Level in and out
   input  wire logic async_in,
   input  wire logic rst_val,
   output var  logic sync_out
);
   logic meta;
   // Reset value is a constant per instance; rst_val is tied by the parent
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meta     <= rst_val;
         sync_out <= rst_val;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule : sync_bit
`default_nettype wire

// ---- edge_find.sv ----
/*
 * Edge finder on an already synchronised level: one-cycle pulses on
 * rise and fall. Assumes its input is in the mclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_find (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Level and edges
   input  wire logic level,
   input  wire logic rst_val,
   output logic      rise,
   output logic      fall
);
   logic prev;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prev <= rst_val;
      end else begin
         prev <= level;
      end
   end
   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule : edge_find
`default_nettype wire

// ---- adc_serial_conversion_sequencer.sv ----
/*
 * Serial port and conversion sequencing of an eight-channel 12-bit
 * successive-approximation converter, rebuilt on a fast system clock.
 * Assumes: mclk at 50 MHz, serial clock slow enough (bench 160 ns) for
 * its edges to be found after two-flop synchronisation; an analog front
 * end that presents the code of the selected channel on conv_code.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_conversion_sequencer (
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             sys_rst,
   // Serial pins from the host
   input  wire logic                             cs_n,
   input  wire logic                             sclk,
   input  wire logic                             din,
   // Serial data pin, three signals
   output logic                                  dout_o,
   output logic                                  dout_oe_n,
   input  wire logic                             dout_i,
   // Analog front end
   input  wire logic [adc_seq_pkg::RESULT_BITS-1:0] conv_code,
   output logic [adc_seq_pkg::CHAN_W-1:0]         sel_channel,
   output logic                                  tracking,
   output logic                                  holding,
   output logic                                  powered_up
);
   import adc_seq_pkg::*;

   // -------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------
   logic cs_n_s;
   logic sclk_s;
   logic din_s;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;

   sync_bit u_sync_cs (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (cs_n),
      .rst_val  (1'b1),
      .sync_out (cs_n_s)
   );
   sync_bit u_sync_sclk (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (sclk),
      .rst_val  (1'b0),
      .sync_out (sclk_s)
   );
   sync_bit u_sync_din (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (din),
      .rst_val  (1'b0),
      .sync_out (din_s)
   );
   // Only the select fall is used; its rise acts through the level
   edge_find u_edge_cs (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .level   (cs_n_s),
      .rst_val (1'b1),
      .rise    (),
      .fall    (cs_fall)
   );
   edge_find u_edge_sclk (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .level   (sclk_s),
      .rst_val (1'b0),
      .rise    (sclk_rise),
      .fall    (sclk_fall)
   );

   // -------------------------------------------------------------------
   // Serial clock events inside a frame
   // -------------------------------------------------------------------
   logic fall_evt;
   logic rise_evt;
   logic new_conv;

   // Edges only count while select is low; the gate is the clock gate
   assign rise_evt = sclk_rise & ~cs_n_s;
   // A select fall with the clock already low (or falling with it)
   // stands in for the first clock fall; with the clock high it waits
   assign fall_evt = (sclk_fall & ~cs_n_s)
                   | (cs_fall & ~sclk_s);

   // -------------------------------------------------------------------
   // Falling edge index within a conversion
   // -------------------------------------------------------------------
   logic [IDX_W-1:0] fall_idx;
   logic [IDX_W-1:0] next_fall_idx;

   // Index 0 means no fall yet in this frame; after 16 it wraps to 1
   assign new_conv = fall_evt
                   & ((fall_idx == IDX_IDLE)
                   | (fall_idx == IDX_LAST));
   always_comb begin
      next_fall_idx = fall_idx;
      if (new_conv) begin
         next_fall_idx = IDX_FIRST;
      end else if (fall_evt) begin
         next_fall_idx = fall_idx + 5'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fall_idx <= IDX_IDLE;
      end else if (cs_n_s) begin
         fall_idx <= IDX_IDLE;
      end else begin
         fall_idx <= next_fall_idx;
      end
   end

   // -------------------------------------------------------------------
   // Track, hold and power phase
   // -------------------------------------------------------------------
   phase_e phase;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phase <= PH_DOWN;
      end else if (cs_n_s) begin
         phase <= PH_DOWN;
      end else if (cs_fall) begin
         // A fall that also counts as edge one tracks at once;
         // otherwise nothing is sampled until the first clock fall
         phase <= fall_evt ? PH_TRACK : PH_DOWN;
      end else if (fall_evt) begin
         case (next_fall_idx)
            IDX_FIRST: begin
               phase <= PH_TRACK;
            end
            IDX_HOLD: begin
               phase <= PH_HOLD;
            end
            default: begin
               phase <= phase;
            end
         endcase
      end
   end

   // Outputs of the phase, each its own flop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tracking   <= 1'b0;
         holding    <= 1'b0;
         powered_up <= 1'b0;
      end else if (cs_n_s) begin
         tracking   <= 1'b0;
         holding    <= 1'b0;
         powered_up <= 1'b0;
      end else if (cs_fall) begin
         tracking   <= fall_evt;
         holding    <= 1'b0;
         powered_up <= 1'b1;
      end else if (fall_evt) begin
         case (next_fall_idx)
            IDX_FIRST: begin
               tracking   <= 1'b1;
               holding    <= 1'b0;
               powered_up <= 1'b1;
            end
            IDX_HOLD: begin
               tracking   <= 1'b0;
               holding    <= 1'b1;
            end
            IDX_LAST: begin
               // Idle between conversions until the next edge one
               powered_up <= 1'b0;
            end
            default: begin
               tracking   <= tracking;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Control word capture
   // -------------------------------------------------------------------
   logic [IDX_W-1:0]     rise_cnt;
   logic [CTRL_BITS-1:0] ctrl_shift;
   logic [CTRL_BITS-1:0] next_channel_select;
   logic [CTRL_BITS-1:0] next_ctrl_shift;

   assign next_ctrl_shift = {ctrl_shift[CTRL_BITS-2:0], din_s};

   // Counting restarts with each conversion so every conversion that
   // sees eight rises delivers a word; rises past the eighth are ignored
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rise_cnt   <= IDX_IDLE;
         ctrl_shift <= CTRL_RESET;
      end else if (cs_n_s || new_conv) begin
         rise_cnt   <= IDX_IDLE;
      end else if (rise_evt && rise_cnt < CTRL_COUNT) begin
         rise_cnt   <= rise_cnt + 5'h01;
         ctrl_shift <= next_ctrl_shift;
      end
   end

   // Word kept across frames until the next full word replaces it
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         next_channel_select <= CTRL_RESET;
      end else if (!cs_n_s && rise_evt
                   && rise_cnt == CTRL_COUNT - 5'h01) begin
         next_channel_select <= next_ctrl_shift;
      end
   end

   // -------------------------------------------------------------------
   // Channel applied to the multiplexer
   // -------------------------------------------------------------------
   // Only bits 5..3 reach the mux; the rest are never read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sel_channel <= CHAN_RESET;
      end else if (new_conv) begin
         sel_channel <= next_channel_select[CHAN_MSB:CHAN_LSB];
      end
   end

   // -------------------------------------------------------------------
   // Result shifting
   // -------------------------------------------------------------------
   logic [RESULT_BITS-1:0] result;

   // The code is taken as hold begins, the sampling instant; it is the
   // front end's plain binary code, one step per supply over 4096.
   // Only a conversion that really tracked may load a new code
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         result <= CODE_RESET;
      end else if (fall_evt && next_fall_idx == IDX_HOLD
                   && phase == PH_TRACK) begin
         result <= conv_code;
      end else if (fall_evt && next_fall_idx > IDX_LAST_Z) begin
         result <= {result[RESULT_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dout_o <= 1'b0;
      end else if (cs_n_s || cs_fall) begin
         dout_o <= 1'b0;
      end else if (fall_evt) begin
         if (next_fall_idx > IDX_LAST_Z) begin
            dout_o <= result[RESULT_BITS-1];
         end else begin
            dout_o <= 1'b0;
         end
      end
   end

   // Select is the output enable, one flop behind the synchronised pin
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dout_oe_n <= 1'b1;
      end else begin
         dout_oe_n <= cs_n_s;
      end
   end

   // The pin's returned level is not needed by this end
   logic unused_dout_i;
   assign unused_dout_i = dout_i;

endmodule : adc_serial_conversion_sequencer
`default_nettype wire

// ---- adc_seq_chk.sv ----
/*
 * Port-level timing checks of the conversion sequencer.
 * Assumes pins move on mclk edges and outputs trail pins by 3 mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk (
   // Clock and reset
   input wire logic                        mclk,
   input wire logic                        sys_rst,
   // Watched pins and outputs
   input wire logic                        cs_n,
   input wire logic                        sclk,
   input wire logic                        dout_o,
   input wire logic                        dout_oe_n,
   input wire logic [adc_seq_pkg::CHAN_W-1:0] sel_channel,
   input wire logic                        tracking,
   input wire logic                        holding,
   input wire logic                        powered_up
);
   import adc_seq_pkg::*;
   logic       prev_sclk;
   logic       sfall;
   logic [3:0] trk_cnt;
   logic [3:0] hold_cnt;
   // -------------------------------------------------------------
   // Serial clock falls counted per phase
   // -------------------------------------------------------------
   assign sfall = prev_sclk & ~sclk;
   always_ff @(posedge mclk) begin
      prev_sclk <= sclk;
   end
   always_ff @(posedge mclk) begin
      trk_cnt <= (tracking && !sys_rst) ? trk_cnt + {3'h0, sfall} : 4'h0;
   end
   always_ff @(posedge mclk) begin
      hold_cnt <= (holding && !sys_rst) ? hold_cnt + {3'h0, sfall} : 4'h0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   oe_follow_a: assert property (dout_oe_n == $past(cs_n, 3))
      else $error("output enable does not follow select");
   deselect_down_a: assert property ($past(cs_n, 3) |->
      !powered_up && !tracking && !holding)
      else $error("activity while deselected");
   lead_zero_a: assert property (tracking |-> !dout_o)
      else $error("nonzero data during track");
   track_len_a: assert property ($fell(tracking) && !dout_oe_n
      |-> trk_cnt == 4'h3)
      else $error("track phase length wrong");
   hold_len_a: assert property ($fell(holding) && tracking
      |-> hold_cnt == 4'hd)
      else $error("hold phase length wrong");
   hold_start_a: assert property ($rose(holding) |->
      $past(tracking) && !tracking && !dout_o)
      else $error("hold did not follow track");
   gap_start_a: assert property ($fell(powered_up) && !dout_oe_n
      |-> holding && !tracking)
      else $error("power gap began out of place");
   gap_end_a: assert property ($rose(tracking) |->
      powered_up && !holding)
      else $error("track began while powered down");
   sel_change_a: assert property ($changed(sel_channel)
      |-> $rose(tracking))
      else $error("channel changed outside track start");
endmodule : adc_seq_chk
`default_nettype wire

// ---- host_model.sv ----
/*
 * Host controller model: frames conversions with select, makes the serial
 * clock at 8 mclk per period, shifts control words, samples results.
 * Assumes mclk at 50 MHz; go is a one-cycle pulse while not busy.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // Frame request
   input  wire logic        go,
   input  wire logic        idle_hi,
   input  wire logic [2:0]  n_conv,
   input  wire logic [7:0]  cut,
   input  wire logic [31:0] word_set,
   // Serial pins
   output logic             cs_n,
   output logic             sclk,
   output logic             din,
   input  wire logic        pin,
   // Results
   output logic             busy,
   output logic [63:0]      res_set
);
   logic [1:0]  cnt;
   logic [7:0]  tg;
   logic [7:0]  lim;
   logic [4:0]  rc;
   logic [1:0]  ci;
   logic [15:0] sh;
   // A cut frame ends early on purpose; otherwise whole conversions
   assign lim = (cut != 8'h00) ? cut : {n_conv, 5'h00} - {7'h00, ~idle_hi};
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cs_n <= 1'b1;
         sclk <= 1'b1;
         din <= 1'b0;
         busy <= 1'b0;
         res_set <= 64'h0;
      end else if (!busy) begin
         // Clock moves to the idle level while deselected
         sclk <= idle_hi;
         if (go) begin
            cs_n <= 1'b0;
            busy <= 1'b1;
            cnt <= 2'h0;
            tg <= 8'h00;
            rc <= 5'h00;
            ci <= 2'h0;
            din <= word_set[7];
         end
      end else begin
         cnt <= cnt + 2'h1;
         if (cnt == 2'h3) begin
            if (tg == lim) begin
               cs_n <= 1'b1;
               busy <= 1'b0;
            end else begin
               sclk <= ~sclk;
               tg <= tg + 8'h01;
               if (!sclk) begin
                  sh <= {sh[14:0], pin};
                  rc <= (rc == 5'd15) ? 5'h00 : rc + 5'h01;
                  if (rc == 5'd15) begin
                     res_set[{ci, 4'h0} +: 16] <= {sh[14:0], pin};
                     ci <= ci + 2'h1;
                  end
               end else begin
                  din <= (rc < 5'd8) ? word_set[{ci, 3'h7} - rc] : rc[0];
               end
            end
         end
      end
   end
endmodule : host_model
`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench: host model frames conversions, a front-end model
 * returns a known code per channel. Assumes the design package is built.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adc_seq_pkg::*;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        go = 1'b0;
   logic        idle_hi = 1'b1;
   logic        tog = 1'b0;
   logic [2:0]  n_conv = 3'h1;
   logic [7:0]  cut = 8'h00;
   logic [31:0] word_set = 32'h0;
   logic [11:0] conv_code = 12'h000;
   logic [63:0] res_set;
   logic [2:0]  sel_channel;
   logic        cs_n, sclk, din, busy, pin;
   logic        dout_o, dout_oe_n, tracking, holding, powered_up;
   int          err_count = 0;
   int          check_count = 0;
   function automatic logic [11:0] code_of(input logic [2:0] c);
      return {c, c, c, c} ^ 12'h5a3;
   endfunction : code_of
   always #10 mclk = ~mclk;
   // Released data line shows a pattern that changes every cycle
   always @(posedge mclk) tog <= ~tog;
   assign pin = dout_oe_n ? tog : dout_o;
   always @(posedge mclk) conv_code <= code_of(sel_channel);
   host_model host (.mclk(mclk), .sys_rst(sys_rst), .go(go),
      .idle_hi(idle_hi), .n_conv(n_conv), .cut(cut), .word_set(word_set),
      .cs_n(cs_n), .sclk(sclk), .din(din), .pin(pin), .busy(busy),
      .res_set(res_set));
   adc_serial_conversion_sequencer dut (.mclk(mclk), .sys_rst(sys_rst),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
      .dout_oe_n(dout_oe_n), .dout_i(pin), .conv_code(conv_code),
      .sel_channel(sel_channel), .tracking(tracking), .holding(holding),
      .powered_up(powered_up));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // One frame; ch lists the expected channel of each conversion
   task automatic frame(input logic [31:0] w, input logic [2:0] n,
      input logic hi, input logic [7:0] c, input logic [11:0] ch);
      int k;
      @(posedge mclk);
      word_set <= w;
      n_conv <= n;
      idle_hi <= hi;
      cut <= c;
      repeat (8) @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      for (k = 0; k < 4000 && busy === 1'b1; k++) @(posedge mclk);
      check({15'h0, busy}, 16'h0000);
      repeat (8) @(posedge mclk);
      for (k = 0; k < n && c == 8'h00; k++)
         check(res_set[16*k +: 16], {4'h0, code_of(ch[3*k +: 3])});
   endtask : frame
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      check({13'h0, sel_channel}, 16'h0000);
      check({14'h0, dout_oe_n, powered_up}, 16'h0002);
      frame(32'h21ff56ab, 3'h4, 1'b1, 8'h00, 12'hea8);
      frame(32'h000037d8, 3'h2, 1'b0, 8'h00, 12'h01c);
      frame(32'h00000008, 3'h1, 1'b1, 8'h0a, 12'h000);
      check({13'h0, sel_channel}, 16'h0006);
      frame(32'h00000000, 3'h1, 1'b1, 8'h00, 12'h006);
      wrap_up();
   end
   initial begin
      #300000;
      err_count++;
      wrap_up();
   end
endmodule : tb
bind adc_serial_conversion_sequencer adc_seq_chk chk (.mclk(mclk),
   .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .dout_o(dout_o),
   .dout_oe_n(dout_oe_n), .sel_channel(sel_channel), .tracking(tracking),
   .holding(holding), .powered_up(powered_up));
`default_nettype wire
